/* File: common/lvt_pkg.sv */
// Constants for the vertical timing and retrace interrupt block
package lvt_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned LVT_LINE_W = 10;
  localparam int unsigned LVT_ALT_W  = 5;
  localparam int unsigned LVT_ADDR_W = 12;
  localparam int unsigned LVT_REG_W  = 16;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [11:0] LVT_OFS_DISP = 12'h000;
  localparam logic [11:0] LVT_OFS_SYNC = 12'h004;
  localparam logic [11:0] LVT_OFS_IRQ  = 12'h008;
  localparam logic [11:0] LVT_OFS_STAT = 12'h00C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned LVT_DISP_LSB     = 0;
  localparam int unsigned LVT_POS_LSB      = 0;
  localparam int unsigned LVT_ALT_LSB      = 11;
  localparam int unsigned LVT_IRQ_EN_BIT   = 0;
  localparam int unsigned LVT_IRQ_FLAG_BIT = 1;
  localparam int unsigned LVT_STAT_LINE_LSB = 0;
  localparam int unsigned LVT_STAT_RETR_BIT = 16;
  localparam int unsigned LVT_STAT_ALT_BIT  = 17;
  localparam int unsigned LVT_STAT_FRM_BIT  = 18;

  // ****************************************
  // Writable masks and reset values
  // ****************************************
  localparam logic [15:0] LVT_DISP_MASK = 16'h03FF;
  localparam logic [15:0] LVT_SYNC_MASK = 16'hFBFF;
  localparam logic [15:0] LVT_DISP_RST  = 16'h0000;
  localparam logic [15:0] LVT_SYNC_RST  = 16'h0000;
  localparam logic        LVT_EN_RST    = 1'b0;

endpackage

/* File: common/lvt_line_if.sv */
// Line timing signals shared between the top and its generators
interface lvt_line_if #(
  parameter int unsigned LINE_W = lvt_pkg::LVT_LINE_W,
  parameter int unsigned ALT_W  = lvt_pkg::LVT_ALT_W
);
  logic              tick;
  logic              soft_clr;
  logic [LINE_W-1:0] line_idx;
  logic [LINE_W-1:0] frame_pos;
  logic [ALT_W-1:0]  alt_count;

  modport ctl (
    output tick,
    output soft_clr,
    output line_idx,
    output frame_pos,
    output alt_count
  );

  modport gen (
    input tick,
    input soft_clr,
    input line_idx,
    input frame_pos,
    input alt_count
  );
endinterface

/* File: rtl/lvt_alt_gen.sv */
// Drive alternation generator counting line ticks
module lvt_alt_gen #(
  parameter int unsigned LINE_W = lvt_pkg::LVT_LINE_W,
  parameter int unsigned ALT_W  = lvt_pkg::LVT_ALT_W
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  lvt_line_if.gen   line_if,
  output logic      alt_o
);

  typedef struct packed {
    logic [ALT_W-1:0] cnt;
    logic             lvl;
  } lvt_alt_state_t;

  lvt_alt_state_t s_reg;
  lvt_alt_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (line_if.soft_clr) begin
      s_next = '0;
    end else if (line_if.tick) begin
      // Every tick counts, emitted on the pins or not
      if (s_reg.cnt >= line_if.alt_count) begin
        s_next.cnt = '0;
        s_next.lvl = ~s_reg.lvl;
      end else begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign alt_o = s_reg.lvl;

endmodule

/* File: rtl/lvt_frame_gen.sv */
// Frame start pulse generator, one line wide
module lvt_frame_gen #(
  parameter int unsigned LINE_W = lvt_pkg::LVT_LINE_W,
  parameter int unsigned ALT_W  = lvt_pkg::LVT_ALT_W
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  lvt_line_if.gen   line_if,
  output logic      frame_o
);

  typedef struct packed {
    logic pulse;
  } lvt_frm_state_t;

  lvt_frm_state_t s_reg;
  lvt_frm_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (line_if.soft_clr) begin
      s_next.pulse = 1'b0;
    end else begin
      // Line index only moves on a tick, so high for one whole line
      s_next.pulse = (line_if.line_idx == line_if.frame_pos);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign frame_o = s_reg.pulse;

endmodule

/* File: rtl/lvt_vertical_timing.sv */
// Vertical timing, alternation, frame pulse and retrace interrupt with APB registers
module lvt_vertical_timing #(
  parameter int unsigned LINE_W = lvt_pkg::LVT_LINE_W,
  parameter int unsigned ALT_W  = lvt_pkg::LVT_ALT_W
) (
  input  wire logic                            clk_i,
  input  wire logic                            rst_b_i,
  input  wire logic                            manual_rst_i,
  input  wire logic                            line_tick_i,
  input  wire logic [LINE_W-1:0]               vtotal_i,
  input  wire logic                            retrace_line_pulse_select_i,
  input  wire logic                            psel_i,
  input  wire logic                            penable_i,
  input  wire logic                            pwrite_i,
  input  wire logic [lvt_pkg::LVT_ADDR_W-1:0]  paddr_i,
  input  wire logic [31:0]                     pwdata_i,
  output logic [31:0]                          prdata_o,
  output logic                                 pready_o,
  output logic                                 pslverr_o,
  output logic                                 line_pulse_o,
  output logic                                 frame_start_pulse_o,
  output logic                                 alternation_o,
  output logic                                 retrace_o,
  output logic                                 retrace_irq_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0]       disp;
    logic [15:0]       sync;
    logic              irq_en;
    logic              irq_flag;
    logic [LINE_W-1:0] line;
    logic              retrace;
    logic              lpulse;
    logic              ack;
    logic              err;
    logic [31:0]       rdata;
  } lvt_top_state_t;

  lvt_top_state_t s_reg;
  lvt_top_state_t s_next;

  lvt_line_if #(
    .LINE_W (LINE_W),
    .ALT_W  (ALT_W)
  ) line_if ();

  logic frame_w;
  logic alt_w;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic lvt_mapped(input logic [lvt_pkg::LVT_ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (a == lvt_pkg::LVT_OFS_DISP) begin
      hit = 1'b1;
    end else if (a == lvt_pkg::LVT_OFS_SYNC) begin
      hit = 1'b1;
    end else if (a == lvt_pkg::LVT_OFS_IRQ) begin
      hit = 1'b1;
    end else if (a == lvt_pkg::LVT_OFS_STAT) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic lvt_is(input logic [lvt_pkg::LVT_ADDR_W-1:0] a,
                                  input logic [lvt_pkg::LVT_ADDR_W-1:0] ofs);
    return (a == ofs);
  endfunction

  // ****************************************
  // Derived timing fields
  // ****************************************
  logic [LINE_W-1:0] disp_lines;
  logic [LINE_W-1:0] frame_pos;
  logic [ALT_W-1:0]  alt_count;
  logic              last_line;
  logic              retrace_start;
  logic              apb_access;
  logic              apb_commit;
  logic              wr_commit;

  assign disp_lines = s_reg.disp[lvt_pkg::LVT_DISP_LSB +: LINE_W];
  assign frame_pos  = s_reg.sync[lvt_pkg::LVT_POS_LSB +: LINE_W];
  assign alt_count  = s_reg.sync[lvt_pkg::LVT_ALT_LSB +: ALT_W];

  // Counter runs 0..total, wraps past the last line
  assign last_line = (s_reg.line >= vtotal_i);

  // Entering the line after the last display line; none if display equals total
  assign retrace_start = line_tick_i && (s_reg.line == disp_lines) &&
                         (disp_lines < vtotal_i);

  // ****************************************
  // APB phases
  // ****************************************
  assign apb_access = psel_i && penable_i;
  // One wait state: data captured first access cycle, released on the second
  assign apb_commit = apb_access && s_reg.ack;
  assign wr_commit  = apb_commit && pwrite_i;

  // ****************************************
  // Read mux
  // ****************************************
  function automatic logic [31:0] lvt_read(input logic [lvt_pkg::LVT_ADDR_W-1:0] a,
                                           input lvt_top_state_t st,
                                           input logic frm,
                                           input logic alt);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (lvt_is(a, lvt_pkg::LVT_OFS_DISP)) begin
      d[15:0] = st.disp & lvt_pkg::LVT_DISP_MASK;
    end else if (lvt_is(a, lvt_pkg::LVT_OFS_SYNC)) begin
      d[15:0] = st.sync & lvt_pkg::LVT_SYNC_MASK;
    end else if (lvt_is(a, lvt_pkg::LVT_OFS_IRQ)) begin
      d[lvt_pkg::LVT_IRQ_EN_BIT]   = st.irq_en;
      d[lvt_pkg::LVT_IRQ_FLAG_BIT] = 1'b0;
    end else if (lvt_is(a, lvt_pkg::LVT_OFS_STAT)) begin
      d[lvt_pkg::LVT_STAT_LINE_LSB +: LINE_W] = st.line;
      d[lvt_pkg::LVT_STAT_RETR_BIT]           = st.retrace;
      d[lvt_pkg::LVT_STAT_ALT_BIT]            = alt;
      d[lvt_pkg::LVT_STAT_FRM_BIT]            = frm;
    end
    return d;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next = s_reg;

    // Bus handshake
    s_next.ack = 1'b0;
    if (apb_access && !s_reg.ack) begin
      s_next.ack   = 1'b1;
      s_next.err   = !lvt_mapped(paddr_i);
      s_next.rdata = pwrite_i ? 32'h0000_0000 : lvt_read(paddr_i, s_reg, frame_w, alt_w);
    end else if (apb_commit) begin
      s_next.err   = 1'b0;
      s_next.rdata = 32'h0000_0000;
    end

    // Register writes; contents assumed stable while displaying
    if (wr_commit && lvt_is(paddr_i, lvt_pkg::LVT_OFS_DISP)) begin
      s_next.disp = pwdata_i[15:0] & lvt_pkg::LVT_DISP_MASK;
    end else if (wr_commit && lvt_is(paddr_i, lvt_pkg::LVT_OFS_SYNC)) begin
      s_next.sync = pwdata_i[15:0] & lvt_pkg::LVT_SYNC_MASK;
    end else if (wr_commit && lvt_is(paddr_i, lvt_pkg::LVT_OFS_IRQ)) begin
      s_next.irq_en = pwdata_i[lvt_pkg::LVT_IRQ_EN_BIT];
    end

    // Flag: cleared by any write to its register, a new set wins
    if (wr_commit && lvt_is(paddr_i, lvt_pkg::LVT_OFS_IRQ)) begin
      s_next.irq_flag = 1'b0;
    end
    if (retrace_start) begin
      s_next.irq_flag = 1'b1;
    end

    // Line counter and retrace window
    s_next.lpulse = 1'b0;
    if (line_tick_i) begin
      s_next.lpulse = !s_reg.retrace || retrace_line_pulse_select_i;
      if (last_line) begin
        s_next.line    = '0;
        s_next.retrace = 1'b0;
      end else begin
        s_next.line = s_reg.line + 1'b1;
      end
      if (retrace_start) begin
        s_next.retrace = 1'b1;
      end
    end

    // Manual reset: timing and flag restart, registers and enable stay
    if (manual_rst_i) begin
      s_next.irq_flag = 1'b0;
      s_next.line     = '0;
      s_next.retrace  = 1'b0;
      s_next.lpulse   = 1'b0;
      s_next.disp     = s_reg.disp;
      s_next.sync     = s_reg.sync;
      s_next.irq_en   = s_reg.irq_en;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg          <= '0;
      s_reg.disp     <= lvt_pkg::LVT_DISP_RST;
      s_reg.sync     <= lvt_pkg::LVT_SYNC_RST;
      s_reg.irq_en   <= lvt_pkg::LVT_EN_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Generators
  // ****************************************
  assign line_if.tick      = line_tick_i;
  assign line_if.soft_clr  = manual_rst_i;
  assign line_if.line_idx  = s_reg.line;
  assign line_if.frame_pos = frame_pos;
  assign line_if.alt_count = alt_count;

  lvt_alt_gen #(
    .LINE_W (LINE_W),
    .ALT_W  (ALT_W)
  ) u_alt (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .line_if (line_if),
    .alt_o   (alt_w)
  );

  lvt_frame_gen #(
    .LINE_W (LINE_W),
    .ALT_W  (ALT_W)
  ) u_frame (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .line_if (line_if),
    .frame_o (frame_w)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata_o            = s_reg.rdata;
  assign pready_o            = s_reg.ack;
  assign pslverr_o           = s_reg.ack && s_reg.err;
  assign line_pulse_o        = s_reg.lpulse;
  assign frame_start_pulse_o = frame_w;
  assign alternation_o       = alt_w;
  assign retrace_o           = s_reg.retrace;
  assign retrace_irq_o       = s_reg.irq_flag && s_reg.irq_en;

endmodule

/* File: dv/lvt_vt_props.sv */
// Concurrent checks on the vertical timing block ports
module lvt_vt_props #(
  parameter int unsigned LINE_W = 10
) (
  input wire logic              clk_i,
  input wire logic              rst_b_i,
  input wire logic              manual_rst_i,
  input wire logic              line_tick_i,
  input wire logic [LINE_W-1:0] vtotal_i,
  input wire logic              retrace_line_pulse_select_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [11:0]       paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              line_pulse_o,
  input wire logic              frame_start_pulse_o,
  input wire logic              alternation_o,
  input wire logic              retrace_o,
  input wire logic              retrace_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] OD = lvt_pkg::LVT_OFS_DISP;
  localparam logic [11:0] OS = lvt_pkg::LVT_OFS_SYNC;
  localparam logic [11:0] OI = lvt_pkg::LVT_OFS_IRQ;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic rd_cyc;
  assign rd_cyc = pready_o && !pwrite_i;
  AST_RDY: assert property (psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("access phase length wrong");
  AST_RSV_DISP: assert property (rd_cyc && paddr_i == OD |-> prdata_o[31:10] == '0)
    else $error("display register reserved bits set");
  AST_RSV_SYNC: assert property (rd_cyc && paddr_i == OS |-> !prdata_o[10])
    else $error("sync register bit 10 set");
  AST_FLAG_RD: assert property (rd_cyc && paddr_i == OI |-> prdata_o[31:1] == '0)
    else $error("interrupt register read shows flag");
  AST_CLR: assert property (
    pready_o && pwrite_i && paddr_i == OI |=> !retrace_irq_o || $rose(retrace_o))
    else $error("write did not clear flag");
  AST_SET: assert property ($rose(retrace_irq_o) |-> $rose(retrace_o))
    else $error("request rose outside retrace start");
  AST_ALT: assert property ($changed(alternation_o) |->
    $past(line_tick_i) || $past(manual_rst_i))
    else $error("alternation moved without a line");
  AST_FRM: assert property (frame_start_pulse_o && line_tick_i && !manual_rst_i
    |-> ##2 !frame_start_pulse_o)
    else $error("frame pulse longer than one line");
  AST_RETR: assert property ($fell(retrace_o) |->
    $past(line_tick_i) || $past(manual_rst_i))
    else $error("retrace ended off a line");
  AST_LP: assert property (line_pulse_o |-> $past(line_tick_i))
    else $error("line pulse without tick");
  AST_MRST: assert property (manual_rst_i |=>
    !retrace_irq_o && !retrace_o && !frame_start_pulse_o)
    else $error("manual reset left outputs set");
  cover property ($rose(retrace_irq_o));
  cover property ($fell(frame_start_pulse_o));
  cover property (pslverr_o);
endmodule

bind lvt_vertical_timing lvt_vt_props #(.LINE_W(LINE_W)) i_props (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .manual_rst_i(manual_rst_i), .line_tick_i(line_tick_i),
  .vtotal_i(vtotal_i), .retrace_line_pulse_select_i(retrace_line_pulse_select_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .line_pulse_o(line_pulse_o), .frame_start_pulse_o(frame_start_pulse_o),
  .alternation_o(alternation_o), .retrace_o(retrace_o), .retrace_irq_o(retrace_irq_o));

/* File: dv/lvt_panel_model.sv */
// Panel model counting line pulses inside frame pulses and alternation flips
module lvt_panel_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic line_pulse_i,
  input wire logic frame_i,
  input wire logic alt_i,
  output int       lines_in_frame_o,
  output int       alt_flips_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic frame_q;
  logic alt_q;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frame_q <= 1'b0;
      alt_q <= 1'b0;
      lines_in_frame_o <= 0;
      alt_flips_o <= 0;
    end else begin
      frame_q <= frame_i;
      alt_q <= alt_i;
      if (frame_i && !frame_q) begin
        lines_in_frame_o <= 0;
      end else if (frame_i && line_pulse_i) begin
        lines_in_frame_o <= lines_in_frame_o + 1;
      end
      if (alt_i != alt_q) begin
        alt_flips_o <= alt_flips_o + 1;
      end
    end
  end
endmodule

/* File: dv/lvt_vertical_timing_tb.sv */
// Self-checking testbench for the vertical timing block
module lvt_vertical_timing_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] OD = lvt_pkg::LVT_OFS_DISP;
  localparam logic [11:0] OS = lvt_pkg::LVT_OFS_SYNC;
  localparam logic [11:0] OI = lvt_pkg::LVT_OFS_IRQ;
  localparam logic [11:0] OT = lvt_pkg::LVT_OFS_STAT;
  logic clk_i = 0, rst_b_i = 0, manual_rst_i = 0, line_tick_i = 0, sel = 1;
  logic psel_i = 0, penable_i = 0, pwrite_i = 0, er, lp, fs, alt, retr, irq, rdy, serr;
  logic [9:0] vtotal_i = 10'h005;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, rd, prd;
  int err_total, tests_run, cyc, lif, altf, a0;
  always #50 clk_i = ~clk_i;
  lvt_vertical_timing i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .manual_rst_i(manual_rst_i), .line_tick_i(line_tick_i),
    .vtotal_i(vtotal_i), .retrace_line_pulse_select_i(sel), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prd), .pready_o(rdy), .pslverr_o(serr), .line_pulse_o(lp),
    .frame_start_pulse_o(fs), .alternation_o(alt), .retrace_o(retr), .retrace_irq_o(irq));
  lvt_panel_model i_panel (.clk_i(clk_i), .rst_b_i(rst_b_i), .line_pulse_i(lp), .frame_i(fs),
    .alt_i(alt), .lines_in_frame_o(lif), .alt_flips_o(altf));
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (rdy !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = prd;
    er = serr;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task tick(input int n);
    repeat (n) begin
      line_tick_i <= 1'b1;
      @(posedge clk_i);
      line_tick_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task mrst;
    manual_rst_i <= 1'b1;
    @(posedge clk_i);
    manual_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset_vals;
    apb(0, OD, 0);
    chk("disp reset", rd, 32'h0);
    apb(0, OS, 0);
    chk("sync reset", rd, 32'h0);
    apb(0, OI, 0);
    chk("irq reset", rd, 32'h0);
    apb(0, 12'h010, 0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    $display("test reset values done");
  endtask
  task t_fields;
    apb(1, OD, 32'hFFFFFFFF);
    apb(0, OD, 0);
    chk("disp field", rd, 32'h3FF);
    apb(1, OS, 32'hFFFFFFFF);
    apb(0, OS, 0);
    chk("sync field", rd, 32'hFBFF);
    apb(1, OI, 32'hFFFFFFFF);
    apb(0, OI, 0);
    chk("irq field", rd, 32'h1);
    apb(1, OI, 32'h0);
    apb(0, OI, 0);
    chk("enable off", rd, 32'h0);
    $display("test register fields done");
  endtask
  task t_frame(input logic s);
    apb(1, OD, 32'h3);
    apb(1, OS, 32'h1002);
    apb(1, OI, 32'h1);
    sel <= s;
    mrst;
    a0 = altf;
    tick(1);
    chk("frame early", {31'h0, fs}, 32'h0);
    tick(1);
    chk("frame on pos", {31'h0, fs}, 32'h1);
    tick(1);
    chk("frame end", {31'h0, fs}, 32'h0);
    chk("lines in frame", lif, 32'h1);
    chk("irq before retrace", {31'h0, irq}, 32'h0);
    tick(1);
    chk("irq at retrace", {30'h0, retr, irq}, 32'h3);
    apb(0, OT, 0);
    chk("status", rd, 32'h0003_0004);
    tick(2);
    chk("retrace wrap", {30'h0, retr, irq}, 32'h1);
    chk("alt flips", altf - a0, 32'h2);
    apb(1, OI, 32'h1);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test frame done");
  endtask
  task t_no_retrace;
    apb(1, OD, 32'h5);
    mrst;
    apb(1, OI, 32'h1);
    tick(12);
    chk("no retrace irq", {30'h0, retr, irq}, 32'h0);
    apb(1, OD, 32'h3);
    apb(1, OI, 32'h0);
    mrst;
    tick(4);
    chk("irq blocked", {30'h0, retr, irq}, 32'h2);
    $display("test no retrace done");
  endtask
  task t_resets;
    apb(1, OD, 32'h3);
    mrst;
    apb(1, OI, 32'h1);
    tick(4);
    chk("irq set", {31'h0, irq}, 32'h1);
    mrst;
    chk("manual clears", {31'h0, irq}, 32'h0);
    apb(0, OI, 0);
    chk("enable kept", rd, 32'h1);
    apb(0, OD, 0);
    chk("disp kept", rd, 32'h3);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    apb(0, OD, 0);
    chk("disp cleared", rd, 32'h0);
    apb(0, OI, 0);
    chk("enable cleared", rd, 32'h0);
    $display("test resets done");
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up;
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    t_reset_vals;
    t_fields;
    t_frame(1'b1);
    t_frame(1'b0);
    t_no_retrace;
    t_resets;
    wrap_up;
  end
endmodule
